// file: pkop_exec.sv
// Decode and one-cycle execute of register OR, halfword pack and preload
`timescale 1ns/1ps
module pkop_exec
  import pkop_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic cond_passed,
  // Register file and flag reads
  input wire logic [31:0] first_operand_val,
  input wire logic [31:0] second_operand_val,
  input wire logic carry_flag,
  // Register write-back
  output logic wr_en,
  output logic [3:0] wr_idx,
  output logic [31:0] wr_data,
  // Program status flags write
  output logic flags_wr,
  output logic flag_n,
  output logic flag_z,
  output logic flag_c,
  // Decode outcomes
  output logic undef_pulse,
  output logic unpred_pulse,
  output logic literal_pld_pulse,
  // Preload hint to memory system
  output logic pld_valid,
  output logic [31:0] pld_addr
);

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [3:0] rn;
  logic [3:0] rd;
  logic [3:0] rm;
  logic [4:0] shift_field;
  logic set_flags;
  logic form_sel;
  logic form_low_bit;

  assign rn = instr_word[RN_HI:RN_LO];
  assign rd = instr_word[RD_HI:RD_LO];
  assign rm = instr_word[RM_HI:0];
  assign set_flags = instr_word[S_BIT];
  assign form_sel = instr_word[FORM_BIT];
  assign form_low_bit = instr_word[T_BIT];
  // Shift amount is the three-bit field above the two-bit field
  assign shift_field = {instr_word[SHIFT_HIGH_HI:SHIFT_HIGH_LO],
                        instr_word[SHIFT_LOW_HI:SHIFT_LOW_LO]}; // RULE6

  // ----------------------------------------------------------------
  // Opcode match
  // ----------------------------------------------------------------
  pkop_op_t op;

  // Base field of all ones is a different instruction for OR and preload
  always_comb begin
    op = OP_NONE;
    if (instr_word[OPC_HI:OPC_LO] == OR_OPC && rn != REG_PC) begin
      op = OP_OR;
    end else if (instr_word[OPC_HI:OPC_LO] == PACK_OPC) begin
      op = OP_PACK;
    end else if (instr_word[OPC_HI:PLD_OPC_LO] == PLD_WIDE_OPC &&
                 instr_word[15:WIDE_MARK_LO] == PLD_WIDE_MARK) begin
      op = OP_PLD_WIDE;
    end else if (instr_word[OPC_HI:PLD_OPC_LO] == PLD_NARROW_OPC &&
                 instr_word[15:NARROW_MARK_LO] == PLD_NARROW_MARK) begin
      op = OP_PLD_NARROW;
    end
  end

  // ----------------------------------------------------------------
  // Shift decode
  // ----------------------------------------------------------------
  pkop_shift_t sh_type;
  logic [5:0] sh_amt;
  logic sh_cin;

  // Pack uses form:'0' as type; a zero field means 32 for right shifts
  always_comb begin
    if (op == OP_PACK) begin
      sh_type = pkop_shift_t'({form_sel, 1'b0}); // RULE6
    end else begin
      sh_type = pkop_shift_t'(instr_word[TYPE_HI:TYPE_LO]);
    end
    sh_amt = {1'b0, shift_field}; // RULE7
    if ((sh_type == SH_LSR || sh_type == SH_ASR) && shift_field == 5'h00) begin
      sh_amt = SHIFT_FULL; // RULE8
    end
    // Pack must not see the carry flag at all
    sh_cin = (op == OP_PACK) ? 1'b0 : carry_flag; // RULE10
  end

  logic [31:0] shifted;
  logic sh_cout;

  pkop_shifter u_shifter (
    .val(second_operand_val),
    .stype(sh_type),
    .amt(sh_amt),
    .carry_in(sh_cin),
    .res(shifted),
    .carry_out(sh_cout)
  );

  // ----------------------------------------------------------------
  // Operation results
  // ----------------------------------------------------------------
  logic [31:0] or_result;
  logic [31:0] pack_result;
  logic [31:0] pld_offset;
  logic [31:0] pld_sum;

  assign or_result = first_operand_val | shifted; // RULE1

  // Halfword merge, direction set by the form-select bit
  always_comb begin
    if (form_sel) begin
      pack_result = {first_operand_val[WORD_W-1:HALF_W],
                     shifted[HALF_W-1:0]}; // RULE9
    end else begin
      pack_result = {shifted[WORD_W-1:HALF_W],
                     first_operand_val[HALF_W-1:0]}; // RULE3
    end
  end

  // Offsets are zero-extended, wide adds and narrow subtracts
  always_comb begin
    if (op == OP_PLD_WIDE) begin
      pld_offset = {20'h00000, instr_word[WIDE_OFS_HI:0]}; // RULE11
    end else begin
      pld_offset = {24'h000000, instr_word[NARROW_OFS_HI:0]}; // RULE12
    end
  end

  pkop_pld_addr u_pld_addr (
    .base(first_operand_val),
    .offset(pld_offset),
    .add(op == OP_PLD_WIDE),
    .addr(pld_sum)
  );

  // ----------------------------------------------------------------
  // Legality checks
  // ----------------------------------------------------------------
  logic pack_undef;
  logic bad_reg;
  logic pld_op;

  assign pack_undef = (op == OP_PACK) && (set_flags || form_low_bit); // RULE4
  assign pld_op = (op == OP_PLD_WIDE) || (op == OP_PLD_NARROW);

  // SP as first operand of OR is unpredictable; registers are never checked for preload
  always_comb begin
    bad_reg = 1'b0; // RULE14
    if (op == OP_PACK) begin
      bad_reg = rd == REG_SP || rd == REG_PC || rn == REG_SP || rn == REG_PC ||
                rm == REG_SP || rm == REG_PC; // RULE5
    end else if (op == OP_OR) begin
      bad_reg = rd == REG_SP || rd == REG_PC || rn == REG_SP ||
                rm == REG_SP || rm == REG_PC;
    end
  end

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  pkop_state_t state_reg;
  pkop_state_t state_next;
  logic exec_ok;

  // Unpredictable forms are flagged yet still executed as written
  assign exec_ok = instr_valid && cond_passed && !pack_undef; // RULE17

  always_comb begin
    state_next = state_reg;
    state_next.wr_en = 1'b0;
    state_next.flags_wr = 1'b0;
    state_next.undef = instr_valid && pack_undef; // RULE4
    state_next.unpred = instr_valid && !pack_undef && bad_reg; // RULE5
    state_next.lit = 1'b0;
    state_next.pld_v = 1'b0;
    // Literal preload forms are handed to their own decoder
    if (instr_valid && rn == REG_PC &&
        ((instr_word[OPC_HI:PLD_OPC_LO] == PLD_WIDE_OPC &&
          instr_word[15:WIDE_MARK_LO] == PLD_WIDE_MARK) ||
         (instr_word[OPC_HI:PLD_OPC_LO] == PLD_NARROW_OPC &&
          instr_word[15:NARROW_MARK_LO] == PLD_NARROW_MARK))) begin
      state_next.lit = 1'b1; // RULE13
    end
    if (exec_ok) begin
      if (op == OP_OR) begin
        state_next.wr_en = 1'b1; // RULE1
        state_next.wr_idx = rd;
        state_next.wr_data = or_result;
        if (set_flags) begin
          state_next.flags_wr = 1'b1; // RULE2
          state_next.flag_n = or_result[WORD_W-1];
          state_next.flag_z = or_result == 32'h00000000;
          state_next.flag_c = sh_cout;
        end
      end else if (op == OP_PACK) begin
        state_next.wr_en = 1'b1; // RULE3
        state_next.wr_idx = rd;
        state_next.wr_data = pack_result;
      end else if (pld_op && rn != REG_PC) begin
        // Hint only: no write-back, no flags, no fault path
        state_next.pld_v = 1'b1; // RULE18
        state_next.pld_addr = pld_sum; // RULE16
      end
    end
  end

  // Registered state, cleared on reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wr_en = state_reg.wr_en;
  assign wr_idx = state_reg.wr_idx;
  assign wr_data = state_reg.wr_data;
  assign flags_wr = state_reg.flags_wr;
  assign flag_n = state_reg.flag_n;
  assign flag_z = state_reg.flag_z;
  assign flag_c = state_reg.flag_c;
  assign undef_pulse = state_reg.undef;
  assign unpred_pulse = state_reg.unpred;
  assign literal_pld_pulse = state_reg.lit;
  assign pld_valid = state_reg.pld_v;
  assign pld_addr = state_reg.pld_addr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_issue_or;
    instr_valid && cond_passed && op == OP_OR;
  endsequence

  sequence s_issue_pack_ok;
    instr_valid && cond_passed && op == OP_PACK && !set_flags && !form_low_bit;
  endsequence

  chk_or_result: assert property ( // RULE1
    s_issue_or |=> wr_en && wr_data == ($past(first_operand_val) | $past(shifted)))
    else $error("OR result wrong");

  chk_or_flags: assert property ( // RULE2
    s_issue_or ##0 set_flags |=> flags_wr && flag_n == wr_data[31] &&
      flag_z == (wr_data == 32'h00000000) && flag_c == $past(sh_cout))
    else $error("OR flag update wrong");

  chk_pack_low: assert property ( // RULE9
    s_issue_pack_ok ##0 !form_sel |=>
      wr_data[15:0] == $past(first_operand_val[15:0]) &&
      wr_data[31:16] == 16'((32'($past(second_operand_val) << $past(shift_field))) >> HALF_W))
    else $error("Bottom/top pack wrong");

  chk_pack_asr32: assert property ( // RULE8
    s_issue_pack_ok ##0 form_sel && shift_field == 5'h00 |=>
      wr_data[15:0] == {16{$past(second_operand_val[31])}} &&
      wr_data[31:16] == $past(first_operand_val[31:16]))
    else $error("Top/bottom zero field not a 32-bit shift");

  chk_pack_undef: assert property ( // RULE4
    instr_valid && op == OP_PACK && (set_flags || form_low_bit) |=>
      undef_pulse && !wr_en && !flags_wr)
    else $error("Undefined pack not refused");

  chk_pack_unpred: assert property ( // RULE5
    instr_valid && op == OP_PACK && !pack_undef && (rd == REG_SP || rm == REG_PC) |=>
      unpred_pulse)
    else $error("Unpredictable pack not flagged");

  chk_pack_noflags: assert property ( // RULE10
    s_issue_pack_ok |=> !flags_wr ##1 !flags_wr || $past(instr_valid))
    else $error("Pack touched flags");

  chk_pld_wide: assert property ( // RULE11
    instr_valid && cond_passed && op == OP_PLD_WIDE && rn != REG_PC |=>
      pld_valid && pld_addr == $past(first_operand_val) + {20'h00000, $past(instr_word[11:0])})
    else $error("Wide preload address wrong");

  chk_pld_narrow: assert property ( // RULE12
    instr_valid && cond_passed && op == OP_PLD_NARROW && rn != REG_PC |=>
      pld_valid && pld_addr == $past(first_operand_val) - {24'h000000, $past(instr_word[7:0])})
    else $error("Narrow preload address wrong");

  chk_pld_literal: assert property ( // RULE13
    instr_valid && op == OP_PLD_WIDE && rn == REG_PC &&
      instr_word[OPC_HI:PLD_OPC_LO] == PLD_WIDE_OPC &&
      instr_word[15:12] == PLD_WIDE_MARK |=> literal_pld_pulse && !pld_valid)
    else $error("Literal preload not redirected");

  chk_pld_sp_base: assert property ( // RULE14
    instr_valid && cond_passed && pld_op && rn == REG_SP |=> pld_valid && !unpred_pulse)
    else $error("SP base preload refused");

  chk_pld_no_state: assert property ( // RULE18
    pld_valid |-> !wr_en && !flags_wr && !undef_pulse)
    else $error("Preload changed state");

  chk_cond_fail_nop: assert property ( // RULE17
    instr_valid && !cond_passed |=> !wr_en && !flags_wr && !pld_valid)
    else $error("Failed condition had effect");

endmodule

// file: pkop_pkg.sv
// Shared constants and types for the pack / OR / preload execute slice
// ----------------------------------------------------------------------
// Summary of operation
// RULE1 - Register OR writes first operand OR shifted second operand to destination.
// RULE2 - Flag-setting OR: N from bit 31, Z on zero, C from shifter, V kept.
// RULE3 - Pack joins one halfword of first operand with other of shifted second.
// RULE4 - Pack with flag-set bit or lowest form bit set is undefined.
// RULE5 - Pack with destination, first or second register 13 or 15 is unpredictable.
// RULE6 - Form-select bit one picks top/bottom; shift type form:0, amount shift_high_field:shift_low_field.
// RULE7 - Bottom/top form: shift zero means none, 1-31 is logical left shift.
// RULE8 - Top/bottom form: arithmetic right shift 1-32, field zero means 32.
// RULE9 - Top/bottom: low half shifted, high half first; bottom/top the reverse.
// RULE10 - Pack ignores carry input and never changes any condition flag.
// RULE11 - Wide preload: zero-extended 12-bit offset added to base register.
// RULE12 - Narrow preload: zero-extended 8-bit offset subtracted from base register.
// RULE13 - Preload with base field all ones goes to the literal preload form.
// RULE14 - Stack pointer as preload base is accepted, not unpredictable.
// RULE15 - Memory system may act on a hint but need not respond.
// RULE16 - Preload address is base plus or minus offset, passed as a hint.
// RULE17 - Every instruction here takes effect only when its condition passes.
// RULE18 - A preload hint never faults nor changes registers or flags.
// ----------------------------------------------------------------------
package pkop_pkg;

  localparam int WORD_W = 32;
  localparam int HALF_W = 16;

  // Opcode matches
  localparam logic [10:0] OR_OPC = 11'h752;
  localparam logic [10:0] PACK_OPC = 11'h756;
  localparam logic [11:0] PLD_WIDE_OPC = 12'hf89;
  localparam logic [11:0] PLD_NARROW_OPC = 12'hf81;
  localparam logic [3:0] PLD_WIDE_MARK = 4'hf;
  localparam logic [7:0] PLD_NARROW_MARK = 8'hfc;

  // Field positions, first halfword in bits 31:16
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 21;
  localparam int PLD_OPC_LO = 20;
  localparam int S_BIT = 20;
  localparam int RN_HI = 19;
  localparam int RN_LO = 16;
  localparam int WIDE_MARK_LO = 12;
  localparam int NARROW_MARK_LO = 8;
  localparam int SHIFT_HIGH_HI = 14;
  localparam int SHIFT_HIGH_LO = 12;
  localparam int RD_HI = 11;
  localparam int RD_LO = 8;
  localparam int SHIFT_LOW_HI = 7;
  localparam int SHIFT_LOW_LO = 6;
  localparam int TYPE_HI = 5;
  localparam int TYPE_LO = 4;
  localparam int FORM_BIT = 5;
  localparam int T_BIT = 4;
  localparam int RM_HI = 3;
  localparam int WIDE_OFS_HI = 11;
  localparam int NARROW_OFS_HI = 7;

  // Special register numbers
  localparam logic [3:0] REG_SP = 4'hd;
  localparam logic [3:0] REG_PC = 4'hf;

  localparam logic [5:0] SHIFT_NONE = 6'h00;
  localparam logic [5:0] SHIFT_FULL = 6'h20;

  typedef enum logic [1:0] {
    SH_LSL = 2'b00,
    SH_LSR = 2'b01,
    SH_ASR = 2'b10,
    SH_ROR = 2'b11
  } pkop_shift_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_OR = 3'b001,
    OP_PACK = 3'b010,
    OP_PLD_WIDE = 3'b011,
    OP_PLD_NARROW = 3'b100
  } pkop_op_t;

  // Whole state of the execute slice
  typedef struct packed {
    logic wr_en;
    logic [3:0] wr_idx;
    logic [31:0] wr_data;
    logic flags_wr;
    logic flag_n;
    logic flag_z;
    logic flag_c;
    logic undef;
    logic unpred;
    logic lit;
    logic pld_v;
    logic [31:0] pld_addr;
  } pkop_state_t;

endpackage

// file: pkop_shifter.sv
// Immediate shifter with carry out for the execute slice
`timescale 1ns/1ps
module pkop_shifter
  import pkop_pkg::*;
(
  // Operand
  input wire logic [31:0] val,
  input wire pkop_shift_t stype,
  input wire logic [5:0] amt,
  input wire logic carry_in,
  // Result
  output logic [31:0] res,
  output logic carry_out
);

  logic [32:0] lsl_w;
  logic [32:0] lsr_w;
  logic [32:0] asr_w;
  logic [31:0] ror_w;

  // Extra bit on each side catches the last bit shifted out
  assign lsl_w = {1'b0, val} << amt;
  assign lsr_w = {val, 1'b0} >> amt;
  assign asr_w = 33'($signed({val, 1'b0}) >>> amt);
  assign ror_w = (val >> amt) | (val << 6'(SHIFT_FULL - amt));

  // Select by type; zero amount passes carry through for LSL, rotate by zero is RRX
  always_comb begin
    res = val;
    carry_out = carry_in;
    case (stype)
      SH_LSL: begin
        res = lsl_w[31:0];
        if (amt != SHIFT_NONE) carry_out = lsl_w[WORD_W];
      end
      SH_LSR: begin
        res = lsr_w[32:1];
        carry_out = lsr_w[0];
      end
      SH_ASR: begin
        res = asr_w[32:1];
        carry_out = asr_w[0];
      end
      default: begin
        if (amt == SHIFT_NONE) begin
          res = {carry_in, val[31:1]};
          carry_out = val[0];
        end else begin
          res = ror_w;
          carry_out = ror_w[31];
        end
      end
    endcase
  end

endmodule

// file: pkop_pld_addr.sv
// Preload address adder for the execute slice
`timescale 1ns/1ps
module pkop_pld_addr (
  // Address terms
  input wire logic [31:0] base,
  input wire logic [31:0] offset,
  input wire logic add,
  // Hint address
  output logic [31:0] addr
);

  // Wraps modulo 2^32, a hint address is never checked
  always_comb begin
    if (add) begin
      addr = base + offset; // RULE16
    end else begin
      addr = base - offset; // RULE16
    end
  end

endmodule

// file: pkop_mem_model.sv
// Memory-system stand-in that receives preload hints from the execute slice
`timescale 1ns/1ps
module pkop_mem_model
  import pkop_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Hint input
  input wire logic pld_valid,
  input wire logic [31:0] pld_addr,
  // Observation for the bench
  output logic [15:0] hint_count,
  output logic [31:0] last_hint
);
  // Hints are only noted; no line is fetched and nothing is answered back
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hint_count <= 16'h0000;
      last_hint <= 32'h0000_0000;
    end else if (pld_valid) begin
      hint_count <= hint_count + 16'h0001;
      last_hint <= pld_addr;
    end
  end
endmodule

// file: tb.sv
// Self-checking bench for the pack / OR / preload execute slice
`timescale 1ns/1ps
module tb
  import pkop_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, cond_passed = 1'b0, carry_flag = 1'b0;
  logic [31:0] instr_word = 32'h0, first_operand_val = 32'h0, second_operand_val = 32'h0;
  logic wr_en, flags_wr, flag_n, flag_z, flag_c, undef_pulse, unpred_pulse;
  logic literal_pld_pulse, pld_valid;
  logic [3:0] wr_idx;
  logic [31:0] wr_data, pld_addr, last_hint, w, r;
  logic [15:0] hint_count;
  int num_errors = 0, comparisons = 0, exp_hints = 0;
  logic [31:0] seed = 32'd51;
  logic e_wr = 0, e_fw = 0, e_n = 0, e_z = 0, e_c = 0, e_ud = 0, e_up = 0, e_lit = 0, e_pv = 0;
  logic [3:0] e_idx = 4'h0;
  logic [31:0] e_data = 32'h0, e_addr = 32'h0, e_last = 32'h0;
  logic [31:0] cq[$];

  pkop_exec u_pkop_exec (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .cond_passed(cond_passed), .first_operand_val(first_operand_val),
    .second_operand_val(second_operand_val), .carry_flag(carry_flag), .wr_en(wr_en),
    .wr_idx(wr_idx), .wr_data(wr_data), .flags_wr(flags_wr), .flag_n(flag_n),
    .flag_z(flag_z), .flag_c(flag_c), .undef_pulse(undef_pulse), .unpred_pulse(unpred_pulse),
    .literal_pld_pulse(literal_pld_pulse), .pld_valid(pld_valid), .pld_addr(pld_addr));
  pkop_mem_model u_pkop_mem_model (.core_clk(core_clk), .rst(rst), .pld_valid(pld_valid),
    .pld_addr(pld_addr), .hint_count(hint_count), .last_hint(last_hint));

  // 100 ns period
  initial begin
    forever #50 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Reference functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Returns {carry, result}; a zero amount means 32 for right shifts, RRX for rotate
  function automatic logic [32:0] shf(logic [31:0] v, logic [1:0] ty, logic [4:0] n, logic ci);
    int k;
    logic [32:0] t;
    logic [63:0] d;
    k = (n == 5'h00) ? 32 : int'(n);
    d = {v, v} >> n;
    case (ty)
      2'b00: return (n == 5'h00) ? {ci, v} : {1'b0, v} << n;
      2'b01: t = {v, 1'b0} >> k;
      2'b10: t = $signed({v, 1'b0}) >>> k;
      default: return (n == 5'h00) ? {v[0], ci, v[31:1]} : {d[31], d[31:0]};
    endcase
    return {t[0], t[32:1]};
  endfunction

  function automatic logic bad(logic [3:0] x);
    return x == REG_SP || x == REG_PC;
  endfunction

  function automatic logic [31:0] enc_or(logic s, logic [3:0] rn, logic [4:0] amt,
      logic [3:0] rd, logic [1:0] ty, logic [3:0] rm);
    return {OR_OPC, s, rn, 1'b0, amt[4:2], rd, amt[1:0], ty, rm};
  endfunction

  function automatic logic [31:0] enc_pk(logic [1:0] st, logic [3:0] rn, logic [4:0] amt,
      logic [3:0] rd, logic fsel, logic [3:0] rm);
    return {PACK_OPC, st[1], rn, 1'b0, amt[4:2], rd, amt[1:0], fsel, st[0], rm};
  endfunction

  function automatic logic [31:0] enc_pl(logic wide, logic [3:0] rn, logic [11:0] ofs);
    return wide ? {PLD_WIDE_OPC, rn, PLD_WIDE_MARK, ofs}
                : {PLD_NARROW_OPC, rn, PLD_NARROW_MARK, ofs[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // Checking and issue
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Outputs of the previous issue are settled at this falling edge
  task automatic check_all();
    chk("wr_en", 32'(wr_en), 32'(e_wr));
    chk("flags_wr", 32'(flags_wr), 32'(e_fw));
    chk("undef", 32'(undef_pulse), 32'(e_ud));
    if (!e_ud) chk("unpred", 32'(unpred_pulse), 32'(e_up));
    chk("literal", 32'(literal_pld_pulse), 32'(e_lit));
    chk("pld_valid", 32'(pld_valid), 32'(e_pv));
    if (e_wr) chk("wr_data", wr_data, e_data);
    if (e_wr) chk("wr_idx", 32'(wr_idx), 32'(e_idx));
    if (e_fw) chk("flags", 32'({flag_n, flag_z, flag_c}), 32'({e_n, e_z, e_c}));
    if (e_pv) chk("pld_addr", pld_addr, e_addr);
  endtask

  // Back to back: each call checks the last word, then presents the next
  task automatic issue(logic [31:0] wd, logic v, logic c, logic [31:0] a, logic [31:0] b);
    logic [32:0] s;
    logic [3:0] rn, rd, rm;
    @(negedge core_clk);
    check_all();
    instr_word = wd;
    instr_valid = v;
    cond_passed = c;
    first_operand_val = a;
    second_operand_val = b;
    carry_flag = seed[7];
    {e_wr, e_fw, e_ud, e_up, e_lit, e_pv} = 6'h00;
    rn = wd[19:16];
    rd = wd[11:8];
    rm = wd[3:0];
    e_idx = rd;
    if (v && wd[31:21] == OR_OPC && rn != REG_PC) begin
      s = shf(b, wd[5:4], {wd[14:12], wd[7:6]}, carry_flag);
      e_up = bad(rd) || rn == REG_SP || bad(rm);
      e_wr = c;
      e_data = a | s[31:0];
      e_fw = c && wd[20];
      e_n = e_data[31];
      e_z = e_data == 32'h0;
      e_c = s[32];
    end else if (v && wd[31:21] == PACK_OPC) begin
      e_ud = wd[20] | wd[4];
      e_up = bad(rd) || bad(rn) || bad(rm);
      s = shf(b, {wd[5], 1'b0}, {wd[14:12], wd[7:6]}, 1'b0);
      e_wr = c && !e_ud;
      e_data = wd[5] ? {a[31:16], s[15:0]} : {s[31:16], a[15:0]};
    end else if (v && wd[15:12] == PLD_WIDE_MARK && (wd[31:20] == PLD_WIDE_OPC ||
        (wd[31:20] == PLD_NARROW_OPC && wd[15:8] == PLD_NARROW_MARK))) begin
      e_lit = rn == REG_PC;
      e_pv = c && !e_lit;
      e_addr = wd[23] ? a + {20'h0, wd[11:0]} : a - {24'h0, wd[7:0]};
    end
    if (e_pv) begin
      exp_hints++;
      e_last = e_addr;
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run is under 500 cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    // Pack shift boundaries in both forms, register and encoding faults, then preload forms
    cq = {
      enc_pk(2'b00, 4'h1, 5'h00, 4'h2, 1'b0, 4'h3), enc_pk(2'b00, 4'h1, 5'h1f, 4'h2, 1'b0, 4'h3),
      enc_pk(2'b00, 4'h1, 5'h00, 4'h2, 1'b1, 4'h3), enc_pk(2'b00, 4'h1, 5'h01, 4'h2, 1'b1, 4'h3),
      enc_pk(2'b00, 4'h1, 5'h04, 4'hd, 1'b0, 4'h3), enc_pk(2'b00, 4'hf, 5'h04, 4'h2, 1'b1, 4'h3),
      enc_pk(2'b10, 4'h1, 5'h04, 4'h2, 1'b0, 4'h3), enc_pk(2'b01, 4'h1, 5'h04, 4'h2, 1'b0, 4'h3),
      enc_pl(1'b1, 4'hd, 12'hfff), enc_pl(1'b0, 4'h1, 12'h0ff), enc_pl(1'b1, 4'hf, 12'h123),
      enc_pl(1'b0, 4'hf, 12'h045), enc_pl(1'b1, 4'h2, 12'h000)};
    for (int t = 0; t < 4; t++) begin
      cq.push_back(enc_or(1'b1, 4'h4, 5'h00, 4'h5, 2'(t), 4'h6));
      cq.push_back(enc_or(1'b1, 4'h0, 5'h01, 4'h1, 2'(t), 4'h2));
    end
    foreach (cq[i]) issue(cq[i], 1'b1, 1'b1, 32'h0000_0010, 32'h8765_4321);
    issue(enc_or(1'b1, 4'h0, 5'h00, 4'h1, 2'b00, 4'h2), 1'b1, 1'b1, 32'h0, 32'h0);
    $display("test corner done");
    for (int i = 0; i < 400; i++) begin
      r = xs();
      case (r[1:0])
        2'b00: w = enc_or(r[2], 4'(r[11:8] % 15), r[16:12], r[20:17], r[22:21], r[26:23]);
        2'b01: w = enc_pk(2'b00, r[11:8], r[16:12], r[20:17], r[21], r[26:23]);
        2'b10: w = enc_pl(r[2], r[11:8], r[23:12]);
        default: w = r;
      endcase
      issue(w, r[1:0] != 2'b11, r[31] | r[30], xs(), xs());
    end
    issue(32'h0, 1'b0, 1'b0, 32'h0, 32'h0);
    @(negedge core_clk);
    chk("hints", 32'(hint_count), 32'(exp_hints));
    chk("last_hint", last_hint, e_last);
    $display("test random done");
    complete_run();
  end
endmodule
